// ==== urt_flag_ctrl.sv ====
// serial port flags, enables, transmit buffer and receiver with register slave
//
// How it works
// RULE1: empty flag high while transmit buffer empty
// RULE2: empty irq requested while flag and enable
// RULE3: data port write clears empty flag
// RULE4: software writes zero to empty bit
// RULE5: done flag set when frame out, buffer empty
// RULE6: done flag cleared by service or one-write
// RULE7: done irq requested when done flag sets
// RULE8: upper parity select inserts parity before stop
// RULE9: transmitter disable waits until all sent
// RULE10: receiver enable takes over serial input
// RULE11: synchronous mode uses external bit clock
// RULE12: frame starts on valid start bit
// RULE13: first stop bit moves frame to buffer
// RULE14: unused high data bits read zero
// RULE15: nine-bit status read before data pops
// RULE16: ready flag high while buffer unread
// RULE17: receiver disable flushes buffer, ready zero
// RULE18: ready irq requested while flag set
// RULE19: buffer holds two plus shift register
// RULE20: parity is data xor, inverted if odd
// RULE21: lower parity select picks odd or even
// RULE22: stop error set when stop sampled zero
// RULE23: irq is flag and enable, global outside
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module urt_flag_ctrl
    import urt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // serial pins
    input wire logic serial_in_pin,
    input wire logic sync_clock_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    output logic rx_pin_takeover,
    // interrupts
    input wire logic tx_done_irq_ack,
    output logic irq_tx_empty,
    output logic irq_tx_done,
    output logic irq_rx_ready
);
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR = 3'b011,
        RX_STOP = 3'b100
    } urt_rx_state_e;

    logic rst_meta;
    logic rst_n;
    logic [7:0] ctrl_b;
    logic [6:0] ctrl_c;
    logic [15:0] baud_div;
    logic txbuf_valid;
    logic [8:0] txbuf_data;
    logic tx_done_flag;
    logic tx_active;
    logic sync_prev;
    logic [15:0] tx_cnt;
    logic [15:0] rx_cnt;
    urt_rx_state_e rx_state;
    logic [8:0] rx_sh;
    logic [3:0] rx_bits;
    logic rx_par;
    logic pend_valid;
    logic [RXE_W-1:0] pend;
    logic dor_hold;
    logic [8:0] mask;
    logic [3:0] nbits;
    logic par_en;
    logic par_odd;
    logic sync_mode;
    logic sync_rise;
    logic tx_tick;
    logic rx_samp;
    logic tx_busy;
    logic tx_line;
    logic tx_fin;
    logic tx_load;
    logic bus_req;
    logic bus_go;
    logic data_wr;
    logic data_rd;
    logic fifo_push;
    logic fifo_full;
    logic fifo_empty;
    logic [RXE_W-1:0] fifo_head;
    logic [8:0] rx_data;
    logic [7:0] stat_a;

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // frame format decode
    assign sync_mode = ctrl_c[CC_SYNC];
    assign par_en = ctrl_c[CC_PAR_HI];
    assign par_odd = ctrl_c[CC_PAR_LO];
    assign nbits = (ctrl_c[CC_SIZE_HI:0] == SIZE_NINE) ? 4'h9 : {2'b01, ctrl_c[1:0]} + 4'h1;
    assign mask = 9'h1ff >> (4'h9 - nbits);
    assign sync_rise = sync_clock_pin && !sync_prev;
    assign tx_tick = sync_mode ? sync_rise : (tx_cnt == 16'h0000);
    assign rx_samp = sync_mode ? sync_rise : (rx_cnt == 16'h0000); // see RULE11

    // bus decode: request answered one cycle after it is seen
    assign bus_req = avs_read || avs_write;
    assign bus_go = bus_req && !avs_waitrequest;
    assign data_wr = bus_go && avs_write && (avs_address == ADDR_DATA);
    assign data_rd = bus_go && avs_read && (avs_address == ADDR_DATA);

    assign stat_a = {!fifo_empty, tx_done_flag, !txbuf_valid, // see RULE16 see RULE1
                     fifo_head[RXE_FE], fifo_head[RXE_DOR], fifo_head[RXE_UPE], 2'b00};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !(bus_req && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                unique case (avs_address)
                    ADDR_DATA: avs_readdata <= {24'h000000, fifo_head[7:0]}; // see RULE14
                    ADDR_STAT_A: avs_readdata <= {24'h000000, stat_a};
                    ADDR_CTRL_B: avs_readdata <= {24'h000000, ctrl_b[7:2],
                                                  fifo_head[8], ctrl_b[0]}; // see RULE15
                    ADDR_CTRL_C: avs_readdata <= {25'h0000000, ctrl_c};
                    ADDR_BAUD: avs_readdata <= {16'h0000, baud_div};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_b <= 8'h00;
            ctrl_c <= CTRL_C_RST;
            baud_div <= BAUD_DIV_RST;
        end else if (bus_go && avs_write) begin
            if (avs_address == ADDR_CTRL_B) begin
                ctrl_b <= {avs_writedata[7:2], 1'b0, avs_writedata[0]};
            end
            if (avs_address == ADDR_CTRL_C) begin
                ctrl_c <= avs_writedata[6:0];
            end
            if (avs_address == ADDR_BAUD) begin
                baud_div <= avs_writedata[15:0];
            end
        end
    end

    // transmit buffer
    assign tx_load = txbuf_valid && !tx_busy && tx_active;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txbuf_valid <= 1'b0;
            txbuf_data <= 9'h000;
        end else if (data_wr) begin
            txbuf_valid <= 1'b1; // see RULE3
            txbuf_data <= {ctrl_b[CB_TX_NINTH], avs_writedata[7:0]} & mask;
        end else if (tx_load) begin
            txbuf_valid <= 1'b0;
        end
    end

    // transmit done flag, set wins over clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_done_flag <= 1'b0;
        end else if (tx_fin && !txbuf_valid) begin
            tx_done_flag <= 1'b1; // see RULE5
        end else if (tx_done_irq_ack ||
                     (bus_go && avs_write && avs_address == ADDR_STAT_A &&
                      avs_writedata[SA_TX_DONE])) begin
            tx_done_flag <= 1'b0; // see RULE6 see RULE4
        end
    end

    // transmitter enable takes effect at once, disable waits for idle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_active <= 1'b0;
        end else if (ctrl_b[CB_TX_EN]) begin
            tx_active <= 1'b1;
        end else if (!txbuf_valid && !tx_busy) begin
            tx_active <= 1'b0; // see RULE9
        end
    end

    // bit timing counters
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_prev <= 1'b0;
            tx_cnt <= 16'h0000;
        end else begin
            sync_prev <= sync_clock_pin;
            tx_cnt <= (tx_cnt == 16'h0000) ? baud_div : tx_cnt - 16'h0001;
        end
    end

    urt_txshift u_txshift (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(tx_tick),
        .load(tx_load),
        .load_data(txbuf_data),
        .num_bits(nbits),
        .par_en(par_en),
        .par_odd(par_odd),
        .stop2(ctrl_c[CC_STOP2]),
        .busy(tx_busy),
        .line(tx_line),
        .done(tx_fin)
    );

    // pin ownership
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            serial_out_pin <= 1'b1;
            serial_out_oe <= 1'b0;
            rx_pin_takeover <= 1'b0;
        end else begin
            serial_out_pin <= tx_line;
            serial_out_oe <= tx_active; // see RULE9
            rx_pin_takeover <= ctrl_b[CB_RX_EN]; // see RULE10
        end
    end

    // receiver
    assign rx_data = (rx_sh >> (4'h9 - nbits)) & mask;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= RX_IDLE;
            rx_cnt <= 16'h0000;
            rx_sh <= 9'h000;
            rx_bits <= 4'h0;
            rx_par <= 1'b0;
            pend_valid <= 1'b0;
            pend <= '0;
            dor_hold <= 1'b0;
        end else if (!ctrl_b[CB_RX_EN]) begin
            rx_state <= RX_IDLE;
            pend_valid <= 1'b0;
            dor_hold <= 1'b0;
        end else begin
            rx_cnt <= (rx_cnt == 16'h0000) ? baud_div : rx_cnt - 16'h0001;
            if (fifo_push) begin
                pend_valid <= 1'b0;
                dor_hold <= 1'b0;
            end
            unique case (rx_state)
                RX_IDLE: begin
                    rx_bits <= 4'h0;
                    if (!serial_in_pin && sync_mode && sync_rise) begin
                        rx_state <= RX_DATA; // see RULE12
                        dor_hold <= dor_hold || (pend_valid && !fifo_push);
                    end else if (!serial_in_pin && !sync_mode) begin
                        rx_cnt <= {1'b0, baud_div[15:1]};
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_samp) begin
                        rx_state <= serial_in_pin ? RX_IDLE : RX_DATA; // see RULE12
                        if (!serial_in_pin) begin
                            dor_hold <= dor_hold || (pend_valid && !fifo_push);
                        end
                    end
                end
                RX_DATA: begin
                    if (rx_samp) begin
                        rx_sh <= {serial_in_pin, rx_sh[8:1]};
                        rx_bits <= rx_bits + 4'h1;
                        if (rx_bits == nbits - 4'h1) begin
                            rx_state <= par_en ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_samp) begin
                        rx_par <= serial_in_pin;
                        rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_samp) begin
                        pend_valid <= 1'b1; // see RULE13 see RULE12
                        pend <= {dor_hold && !fifo_push, !serial_in_pin, // see RULE22
                                 par_en && (rx_par != ((^rx_data) ^ par_odd)), // see RULE21
                                 rx_data};
                        rx_state <= RX_IDLE;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    assign fifo_push = pend_valid && !fifo_full;

    urt_rxfifo u_rxfifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .push(fifo_push), // see RULE19
        .push_data(pend),
        .full(fifo_full),
        .pop(data_rd), // see RULE15
        .flush(!ctrl_b[CB_RX_EN]), // see RULE17
        .head(fifo_head),
        .empty(fifo_empty)
    );

    // interrupt request levels
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_tx_empty <= 1'b0;
            irq_tx_done <= 1'b0;
            irq_rx_ready <= 1'b0;
        end else begin
            irq_tx_empty <= !txbuf_valid && ctrl_b[CB_TXE_IRQ_EN]; // see RULE2 see RULE23
            irq_tx_done <= tx_done_flag && ctrl_b[CB_TXD_IRQ_EN]; // see RULE7
            irq_rx_ready <= !fifo_empty && ctrl_b[CB_RX_IRQ_EN]; // see RULE18
        end
    end
endmodule // urt_flag_ctrl
`default_nettype wire

// ==== urt_flag_ctrl_monitor.sv ====
// checker for the serial port flag and control block
`timescale 1ns/1ps
`default_nettype none
module urt_flag_ctrl_monitor
    import urt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // pins and interrupts
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    input wire logic rx_pin_takeover,
    input wire logic tx_done_irq_ack,
    input wire logic irq_tx_empty,
    input wire logic irq_tx_done,
    input wire logic irq_rx_ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ctrl_wr;
        avs_write && !avs_waitrequest && avs_address == ADDR_CTRL_B;
    endsequence
    a_wait_answer: assert property (s_req |=> !avs_waitrequest)
        else $error("no answer");
    a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
    a_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
        else $error("stray answer");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address > ADDR_BAUD |-> avs_readdata == 32'h0)
        else $error("unmapped read");
    a_takeover_on: assert property (
        s_ctrl_wr ##0 avs_writedata[CB_RX_EN] |-> ##[1:3] rx_pin_takeover)
        else $error("pin not taken");
    a_takeover_off: assert property (
        s_ctrl_wr ##0 !avs_writedata[CB_RX_EN] |-> ##[1:3] !rx_pin_takeover)
        else $error("pin kept");
    a_empty_irq_off: assert property (
        s_ctrl_wr ##0 !avs_writedata[CB_TXE_IRQ_EN] |-> ##[1:3] !irq_tx_empty)
        else $error("empty irq on");
    a_done_ack: assert property (tx_done_irq_ack |-> ##[1:3] !irq_tx_done)
        else $error("done irq kept");
    a_rx_flush_irq: assert property (!rx_pin_takeover [*3] |-> !irq_rx_ready)
        else $error("ready irq on");
    a_start_owned: assert property ($fell(serial_out_pin) |-> serial_out_oe)
        else $error("low unowned");
    a_release_idle: assert property ($fell(serial_out_oe) |-> $past(serial_out_pin))
        else $error("released mid frame");
    // four clocks a bit at baud 3
    a_bit_len: assert property ($fell(serial_out_pin) |-> !serial_out_pin [*4])
        else $error("short low bit");
endmodule // urt_flag_ctrl_monitor
bind urt_flag_ctrl urt_flag_ctrl_monitor u_mon (.*);
`default_nettype wire

// ==== urt_flag_ctrl_tb.sv ====
// testbench for the serial port flag and control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module urt_flag_ctrl_tb
    import urt_pkg::*;
;
    logic clk_sys = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic tx_done_irq_ack = 1'b0;
    logic [4:0] avs_address = '0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, serial_out_pin, serial_out_oe, rx_pin_takeover;
    logic irq_tx_empty, irq_tx_done, irq_rx_ready, serial_in_pin, sync_clock_pin;
    logic [8:0] d[3];
    logic [9:0] f;
    int bad_count = 0, total_checks = 0, nb;
    int sizes[5] = '{0, 1, 2, 3, 7};
    urt_flag_ctrl uut (.*);
    urt_remote_model m (.*);
    initial forever #50 clk_sys = ~clk_sys;
    function automatic logic par_bit(input logic [8:0] v, input logic odd);
        return ^v ^ odd;
    endfunction
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic put_tx(input logic [8:0] v);
        do bus(0, ADDR_STAT_A, 0); while (q[SA_TX_EMPTY] !== 1'b1);
        bus(1, ADDR_DATA, 32'(v));
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(45));
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        bus(0, ADDR_STAT_A, 0);
        `CHK("status_a", 32'h20, q);
        bus(0, ADDR_CTRL_C, 0);
        `CHK("control_c", CTRL_C_RST, q);
        bus(0, ADDR_BAUD, 0);
        `CHK("baud", BAUD_DIV_RST, q);
        bus(1, 5'h14, 32'hffff);
        bus(0, 5'h14, 0);
        `CHK("unmapped", 0, q);
        bus(1, ADDR_BAUD, 32'h3);
        $display("test reset done");
        for (int p = 0; p < 4; p++) begin
            bus(1, ADDR_CTRL_C, 32'h3 | (p << CC_PAR_LO));
            m.pen = p[1];
            bus(1, ADDR_CTRL_B, 32'h68);
            repeat (2) @(posedge clk_sys);
            `CHK("irq_tx_empty", 1, irq_tx_empty);
            d[0] = 9'($urandom & 8'hff);
            d[1] = 9'($urandom & 8'hff);
            put_tx(d[0]);
            put_tx(d[1]);
            bus(0, ADDR_STAT_A, 0);
            `CHK("tx_empty_pending", 0, q[SA_TX_EMPTY]);
            bus(1, ADDR_CTRL_B, 32'h60);
            repeat (2) @(posedge clk_sys);
            `CHK("oe_held", 1, serial_out_oe);
            for (int i = 0; i < 300 && m.tx_q.size() < 2; i++) @(posedge clk_sys);
            `CHK("tx_frames", 2, m.tx_q.size());
            for (int i = 0; i < 2 && m.tx_q.size() > 0; i++) begin
                f = m.tx_q.pop_front();
                `CHK("tx_data", d[i], f[8:0]);
                if (p[1]) `CHK("tx_parity", par_bit(d[i], p[0]), f[9]);
            end
            for (int i = 0; i < 50 && serial_out_oe; i++) @(posedge clk_sys);
            `CHK("oe_released", 0, serial_out_oe);
            bus(0, ADDR_STAT_A, 0);
            `CHK("tx_done", 1, q[SA_TX_DONE]);
            `CHK("irq_tx_done", 1, irq_tx_done);
            if (p[0]) begin
                tx_done_irq_ack <= 1'b1;
                @(posedge clk_sys);
                tx_done_irq_ack <= 1'b0;
            end else bus(1, ADDR_STAT_A, 32'h40);
            bus(0, ADDR_STAT_A, 0);
            `CHK("tx_done_clear", 0, q[SA_TX_DONE]);
            $display("test tx parity %0d done", p);
        end
        bus(1, ADDR_CTRL_B, 32'h90);
        repeat (2) @(posedge clk_sys);
        `CHK("takeover", 1, rx_pin_takeover);
        foreach (sizes[s]) begin
            nb = (sizes[s] == 7) ? 9 : sizes[s] + 5;
            bus(1, ADDR_CTRL_C, 32'(sizes[s]));
            for (int i = 0; i < 3; i++) begin
                d[i] = 9'($urandom & ((1 << nb) - 1));
                m.send(d[i], nb, i != 1);
            end
            repeat (4) @(posedge clk_sys);
            `CHK("irq_rx_ready", 1, irq_rx_ready);
            for (int i = 0; i < 3; i++) begin
                bus(0, ADDR_STAT_A, 0);
                `CHK("rx_ready", 1, q[SA_RX_READY]);
                `CHK("stop_err", i == 1, q[SA_STOP_ERR]);
                bus(0, ADDR_CTRL_B, 0);
                `CHK("ninth", d[i][8], q[CB_RX_NINTH]);
                bus(0, ADDR_DATA, 0);
                `CHK("rx_data", d[i][7:0], q);
            end
            bus(0, ADDR_STAT_A, 0);
            `CHK("rx_drained", 0, q[SA_RX_READY]);
            repeat (3) @(posedge clk_sys);
            `CHK("irq_rx_off", 0, irq_rx_ready);
            $display("test rx size %0d done", nb);
        end
        bus(1, ADDR_CTRL_C, 32'h43);
        d[0] = 9'($urandom & 8'hff);
        m.send(d[0], 8, 1'b1);
        m.send(9'h0a5, 8, 1'b1);
        bus(0, ADDR_DATA, 0);
        `CHK("sync_data", d[0], q);
        bus(1, ADDR_CTRL_B, 32'h80);
        repeat (3) @(posedge clk_sys);
        `CHK("flush_irq", 0, irq_rx_ready);
        bus(1, ADDR_CTRL_B, 32'h90);
        bus(0, ADDR_STAT_A, 0);
        `CHK("flush_ready", 0, q[SA_RX_READY]);
        $display("test sync and flush done");
        tally_and_finish();
    end
endmodule // urt_flag_ctrl_tb
`default_nettype wire

// ==== urt_pkg.sv ====
// constants shared by the serial port flag and control block
package urt_pkg;
    // register byte offsets
    localparam logic [4:0] ADDR_DATA = 5'h00;
    localparam logic [4:0] ADDR_STAT_A = 5'h04;
    localparam logic [4:0] ADDR_CTRL_B = 5'h08;
    localparam logic [4:0] ADDR_CTRL_C = 5'h0c;
    localparam logic [4:0] ADDR_BAUD = 5'h10;
    // status_reg_a fields
    localparam int SA_RX_READY = 7;
    localparam int SA_TX_DONE = 6;
    localparam int SA_TX_EMPTY = 5;
    localparam int SA_STOP_ERR = 4;
    localparam int SA_OVERRUN = 3;
    localparam int SA_PAR_ERR = 2;
    // control_reg_b fields
    localparam int CB_RX_IRQ_EN = 7;
    localparam int CB_TXD_IRQ_EN = 6;
    localparam int CB_TXE_IRQ_EN = 5;
    localparam int CB_RX_EN = 4;
    localparam int CB_TX_EN = 3;
    localparam int CB_RX_NINTH = 1;
    localparam int CB_TX_NINTH = 0;
    // control_reg_c fields
    localparam int CC_SYNC = 6;
    localparam int CC_PAR_HI = 5;
    localparam int CC_PAR_LO = 4;
    localparam int CC_STOP2 = 3;
    localparam int CC_SIZE_HI = 2;
    // reset values and the nine-bit size code
    localparam logic [6:0] CTRL_C_RST = 7'h03;
    localparam logic [15:0] BAUD_DIV_RST = 16'h0040;
    localparam logic [2:0] SIZE_NINE = 3'h7;
    // receive buffer entry: overrun, stop error, parity error, nine data bits
    localparam int RXE_W = 12;
    localparam int RXE_DOR = 11;
    localparam int RXE_FE = 10;
    localparam int RXE_UPE = 9;
endpackage

// ==== urt_remote_model.sv ====
// remote serial transceiver model
`timescale 1ns/1ps
`default_nettype none
module urt_remote_model #(
    parameter int BIT = 4
) (
    // clock
    input wire logic clk_sys,
    // lines
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    output var logic serial_in_pin,
    output var logic sync_clock_pin
);
    int nb = 8;
    logic pen = 1'b0;
    logic [9:0] tx_q[$];
    initial begin
        serial_in_pin = 1'b1;
        sync_clock_pin = 1'b0;
    end
    // one frame; clock idles low between frames
    task automatic send(input logic [8:0] d, input int n, input logic stop_ok);
        logic b;
        for (int i = 0; i < n + 2; i++) begin
            b = (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : stop_ok;
            for (int k = 0; k < BIT; k++) begin
                @(posedge clk_sys);
                serial_in_pin <= b;
                sync_clock_pin <= (k == 1 || k == 2);
            end
        end
        @(posedge clk_sys);
        serial_in_pin <= 1'b1;
        sync_clock_pin <= 1'b0;
        repeat (BIT) @(posedge clk_sys);
    endtask
    // transmit line capture, parity in bit 9
    initial begin
        logic [9:0] f;
        forever begin
            @(posedge clk_sys);
            if (serial_out_oe && !serial_out_pin) begin
                f = '0;
                repeat (BIT / 2) @(posedge clk_sys);
                for (int i = 0; i < nb + pen; i++) begin
                    repeat (BIT) @(posedge clk_sys);
                    f[(i < nb) ? i : 9] = serial_out_pin;
                end
                repeat (BIT) @(posedge clk_sys);
                tx_q.push_back(f);
            end
        end
    end
endmodule // urt_remote_model
`default_nettype wire

// ==== urt_rxfifo.sv ====
// two-entry receive buffer with flush
`timescale 1ns/1ps
`default_nettype none
module urt_rxfifo
    import urt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // fill side
    input wire logic push,
    input wire logic [RXE_W-1:0] push_data,
    output logic full,
    // drain side
    input wire logic pop,
    input wire logic flush,
    output logic [RXE_W-1:0] head,
    output logic empty
);
    logic [RXE_W-1:0] mem [0:1];
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;

    assign full = (count == 2'h2);
    assign empty = (count == 2'h0);
    assign head = mem[rd_ptr];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (push && !full) begin
            mem[wr_ptr] <= push_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else if (flush) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push && !full) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop && !empty) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push && !full} - {1'b0, pop && !empty};
        end
    end
endmodule // urt_rxfifo
`default_nettype wire

// ==== urt_txshift.sv ====
// transmit shift register with start, data, parity and stop bits
`timescale 1ns/1ps
`default_nettype none
module urt_txshift
    import urt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // bit timing
    input wire logic tick,
    // frame load
    input wire logic load,
    input wire logic [8:0] load_data,
    input wire logic [3:0] num_bits,
    input wire logic par_en,
    input wire logic par_odd,
    input wire logic stop2,
    // state and line
    output logic busy,
    output logic line,
    output logic done
);
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_PAR = 3'b011,
        TX_STOP1 = 3'b100,
        TX_STOP2 = 3'b101
    } urt_tx_state_e;

    urt_tx_state_e state;
    logic [8:0] shreg;
    logic [3:0] cnt;
    logic par_bit;

    assign busy = (state != TX_IDLE);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= TX_IDLE;
            shreg <= 9'h000;
            cnt <= 4'h0;
            par_bit <= 1'b0;
            line <= 1'b1;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                TX_IDLE: begin
                    if (load) begin
                        shreg <= load_data;
                        par_bit <= (^load_data) ^ par_odd; // see RULE20 see RULE21
                        state <= TX_START;
                    end
                end
                TX_START: begin
                    if (tick) begin
                        line <= 1'b0;
                        cnt <= 4'h0;
                        state <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tick) begin
                        if (cnt == num_bits) begin
                            line <= par_en ? par_bit : 1'b1; // see RULE8
                            state <= par_en ? TX_PAR : TX_STOP1;
                        end else begin
                            line <= shreg[0];
                            shreg <= {1'b0, shreg[8:1]};
                            cnt <= cnt + 4'h1;
                        end
                    end
                end
                TX_PAR: begin
                    if (tick) begin
                        line <= 1'b1;
                        state <= TX_STOP1;
                    end
                end
                TX_STOP1: begin
                    if (tick) begin
                        state <= stop2 ? TX_STOP2 : TX_IDLE;
                        done <= !stop2;
                    end
                end
                TX_STOP2: begin
                    if (tick) begin
                        state <= TX_IDLE;
                        done <= 1'b1;
                    end
                end
                default: begin
                    state <= TX_IDLE;
                    line <= 1'b1;
                end
            endcase
        end
    end
endmodule // urt_txshift
`default_nettype wire
